// [bml_loader.sv]
/*
 Boot mode select and image loader top.
 Assumes a ROM byte engine on the rom_tx/rom_rx ports, a host message
 decoder on msg_*, and an init_busy level from PLL and SDRAM set-up.
*/
`timescale 1ns/1ps
module bml_loader
    import bml_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [STRAP_W-1:0] boot_select_pins,
    input wire logic init_busy,
    input wire logic msg_valid,
    input wire bml_msg_s msg,
    input wire logic resp_read,
    input wire logic rom_tx_ready,
    input wire logic rom_rx_valid,
    input wire logic [7:0] rom_rx_byte,
    input wire logic rom_rx_last,
    output bml_mode_e boot_mode,
    output bml_state_e boot_state,
    output bml_rom_cfg_s rom_cfg,
    output logic rom_tx_valid,
    output logic [7:0] rom_tx_byte,
    output logic rom_clk_tick,
    output logic [7:0] resp_code,
    output logic host_stall_pin_n,
    output logic host_read_pending_pin_n,
    output logic parallel_read_pending_pin_n,
    output logic app_run
);
    typedef struct packed {
        bml_state_e state;
        logic [STRAP_W-1:0] pins;
        bml_mode_e mode;
        bml_rom_cfg_s cfg;
        logic [3:0] idx;
        logic tx_valid;
        logic [7:0] tx_byte;
        logic [7:0] resp;
        logic stall_n;
        logic pend_n;
        logic ppend_n;
        logic run;
    } bml_top_s;

    bml_top_s q;
    bml_top_s d;
    logic sum_clr;
    logic sum_add;
    logic [SUM_W-1:0] sum_val;
    logic [SUM_W-1:0] sum;
    logic div_en;
    logic take;

    function automatic bml_mode_e decode(input logic [STRAP_W-1:0] p);
        bml_mode_e m;
        m = S_PAR_MUX;
        if (p[2])
        begin
            case (p[1:0])
                2'b00: m = S_I2C;
                2'b01: m = S_SPI;
                2'b10: m = S_PAR_SEP;
                default: m = S_PAR_RW;
            endcase
        end
        else
        begin
            case (p[1:0])
                2'b00: m = p[3] ? M_SPI1 : M_I2C;
                2'b01: m = p[3] ? M_SPI3 : M_SPI2;
                2'b10: m = p[3] ? M_FL16 : M_FL8;
                default: m = S_PAR_MUX;
            endcase
        end
        return m;
    endfunction

    function automatic bml_rom_cfg_s master_cfg(input bml_mode_e m);
        bml_rom_cfg_s c;
        c = '0;
        c.addr = IMAGE_START;
        c.cs_pin = CS_PIN_DEFAULT;
        c.kind = ROM_SPI;
        case (m)
            M_I2C:
            begin
                c.kind = ROM_I2C;
                c.addr_bytes = ADDR_16;
                c.div = I2C_DIV;
            end
            M_SPI1:
            begin
                c.cmd = SPI1_CMD;
                c.addr_bytes = ADDR_16;
                c.div = SPI1_DIV;
            end
            M_SPI2:
            begin
                c.cmd = SPI2_CMD;
                c.addr_bytes = ADDR_24;
                c.dummy = SPI2_DUMMY;
                c.div = SPI23_DIV;
            end
            M_SPI3:
            begin
                c.cmd = SPI3_CMD;
                c.addr_bytes = ADDR_24;
                c.div = SPI23_DIV;
            end
            default:
            begin
                c.kind = ROM_PAR;
                c.wide = (m == M_FL16);
                c.ratio = FLASH_RATIO;
                c.little = 1'b1;
                c.cs_low = 1'b1;
                c.oe_dly = FLASH_OE_DLY;
                c.acc_dly = FLASH_ACC_DLY;
                c.div = 8'(FLASH_RATIO);
            end
        endcase
        return c;
    endfunction

    function automatic logic [3:0] hdr_len(input bml_rom_cfg_s c);
        if (c.kind == ROM_PAR)
            return 4'h0;
        return 4'h1 + {2'b00, c.addr_bytes} + {1'b0, c.dummy};
    endfunction

    function automatic logic [7:0] hdr_byte(input bml_rom_cfg_s c, input logic [3:0] i);
        logic [3:0] k;
        k = {2'b00, c.addr_bytes} - i;
        if (i == 4'h0)
            return (c.kind == ROM_I2C) ? {I2C_DEV_ADDR, 1'b0} : c.cmd;
        if (i > {2'b00, c.addr_bytes})
            return 8'h00;
        case (k)
            4'h0: return c.addr[7:0];
            4'h1: return c.addr[15:8];
            default: return c.addr[23:16];
        endcase
    endfunction

    // Next state
    always_comb
    begin
        d = q;
        sum_clr = 1'b0;
        sum_add = 1'b0;
        sum_val = msg.data;
        take = msg_valid && q.stall_n && !init_busy && q.mode[3]
            && (q.state == PH_IDLE || q.state == PH_HOSTLOAD);
        if (resp_read)
        begin
            d.pend_n = 1'b1;
            d.ppend_n = 1'b1;
        end
        if (msg_valid && init_busy)
            d.stall_n = 1'b0;
        else if (!init_busy)
            d.stall_n = 1'b1;
        case (q.state)
            PH_CAPTURE:
            begin
                d.pins = boot_select_pins;
                d.mode = decode(boot_select_pins);
                d.cfg = master_cfg(d.mode);
                sum_clr = 1'b1;
                if (d.mode[3])
                begin
                    d.state = PH_IDLE;
                end
                else if (hdr_len(d.cfg) == 4'h0)
                begin
                    d.state = PH_FETCH;
                end
                else
                begin
                    d.state = PH_HDR;
                    d.tx_valid = 1'b1;
                    d.tx_byte = hdr_byte(d.cfg, 4'h0);
                    d.idx = 4'h0;
                end
            end
            PH_IDLE, PH_HOSTLOAD:
            begin
                if (take)
                begin
                    case (msg.code)
                        MSG_SLAVE_BOOT:
                        begin
                            d.state = PH_HOSTLOAD;
                            d.resp = RSP_START;
                            sum_clr = 1'b1;
                        end
                        MSG_ROM_BOOT:
                        begin
                            d.cfg = master_cfg(M_SPI3);
                            d.cfg.kind = bml_rom_e'(msg.arg[ARG_KIND_LSB +: 2]);
                            d.cfg.addr_bytes = (d.cfg.kind == ROM_I2C) ? ADDR_16 : ADDR_24;
                            d.cfg.addr = msg.data[23:0];
                            d.cfg.div = msg.arg[ARG_DIV_LSB +: 8];
                            d.cfg.cs_pin = msg.arg[ARG_CS_LSB +: 6];
                            if (d.cfg.kind == ROM_PAR)
                            begin
                                d.cfg.ratio = FLASH_RATIO;
                                d.cfg.little = 1'b1;
                                d.cfg.cs_low = 1'b1;
                                d.cfg.acc_dly = FLASH_ACC_DLY;
                            end
                            d.resp = RSP_START;
                            sum_clr = 1'b1;
                            d.idx = 4'h0;
                            d.tx_byte = hdr_byte(d.cfg, 4'h0);
                            d.tx_valid = (hdr_len(d.cfg) != 4'h0);
                            d.state = d.tx_valid ? PH_HDR : PH_FETCH;
                        end
                        MSG_WORD:
                        begin
                            sum_add = (q.state == PH_HOSTLOAD);
                        end
                        MSG_END:
                        begin
                            d.resp = (msg.data == sum) ? RSP_LOAD_OK : RSP_SUM_ERR;
                            d.state = PH_IDLE;
                        end
                        MSG_RUN:
                        begin
                            d.resp = RSP_RUN;
                            d.run = 1'b1;
                            d.state = PH_RUN;
                        end
                        default:
                        begin
                            d.state = q.state;
                        end
                    endcase
                    if (msg.code != MSG_WORD)
                    begin
                        d.pend_n = !(q.mode != S_PAR_SEP && q.mode != S_PAR_RW
                            && q.mode != S_PAR_MUX);
                        d.ppend_n = !(q.mode == S_PAR_SEP || q.mode == S_PAR_RW
                            || q.mode == S_PAR_MUX);
                    end
                end
            end
            PH_HDR:
            begin
                if (rom_tx_ready && q.tx_valid)
                begin
                    if (q.idx + 4'h1 == hdr_len(q.cfg))
                    begin
                        d.tx_valid = 1'b0;
                        d.state = PH_FETCH;
                    end
                    else
                    begin
                        d.idx = q.idx + 4'h1;
                        d.tx_byte = hdr_byte(q.cfg, q.idx + 4'h1);
                    end
                end
            end
            PH_FETCH:
            begin
                sum_val = {{(SUM_W-8){1'b0}}, rom_rx_byte};
                if (rom_rx_valid && !rom_rx_last)
                begin
                    sum_add = 1'b1;
                end
                else if (rom_rx_valid)
                begin
                    d.resp = (sum[7:0] + rom_rx_byte == 8'h00) ? RSP_LOAD_OK : RSP_SUM_ERR;
                    // Serial pin for master and serial slave modes, parallel pin otherwise
                    d.pend_n = (q.mode == S_PAR_SEP) || (q.mode == S_PAR_RW)
                        || (q.mode == S_PAR_MUX);
                    d.ppend_n = !d.pend_n;
                    d.run = !q.mode[3] && (d.resp == RSP_LOAD_OK);
                    d.state = d.run ? PH_RUN : PH_IDLE;
                end
            end
            PH_RUN:
            begin
                d.state = PH_RUN;
            end
            default:
            begin
                d.state = PH_CAPTURE;
            end
        endcase
    end

    // Register update; strap only reloads through reset
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            q <= '0;
            q.stall_n <= 1'b1;
            q.pend_n <= 1'b1;
            q.ppend_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign div_en = (q.state == PH_HDR) || (q.state == PH_FETCH);

    bml_div #(.W(DIV_W)) u_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .en(div_en),
        .div(q.cfg.div),
        .tick(rom_clk_tick)
    );

    bml_sum #(.W(SUM_W)) u_sum (
        .ref_clk(ref_clk),
        .rst(rst),
        .clr(sum_clr),
        .add(sum_add),
        .val(sum_val),
        .sum(sum)
    );

    assign boot_mode = q.mode;
    assign boot_state = q.state;
    assign rom_cfg = q.cfg;
    assign rom_tx_valid = q.tx_valid;
    assign rom_tx_byte = q.tx_byte;
    assign resp_code = q.resp;
    assign host_stall_pin_n = q.stall_n;
    assign host_read_pending_pin_n = q.pend_n;
    assign parallel_read_pending_pin_n = q.ppend_n;
    assign app_run = q.run;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_end_taken;
        take && msg.code == MSG_END;
    endsequence

    sequence s_run_taken;
        take && msg.code == MSG_RUN;
    endsequence

    a_strap_capture: assert property (!rst && q.state == PH_CAPTURE
        |=> q.pins == $past(boot_select_pins))
        else $error("strap not captured at release");
    a_strap_hold: assert property (q.state != PH_CAPTURE |=> $stable(q.pins))
        else $error("strap changed after capture");
    a_master_decode: assert property (q.state != PH_CAPTURE && !q.pins[2] && q.pins[1:0] == 2'b01
        |-> q.mode == (q.pins[3] ? M_SPI3 : M_SPI2))
        else $error("master mode decode wrong");
    a_slave_decode: assert property (q.state != PH_CAPTURE && q.pins[2]
        |-> q.mode[3] && q.mode[1:0] == q.pins[1:0])
        else $error("slave mode decode wrong");
    a_spi2_header: assert property (q.mode == M_SPI2 && q.state == PH_HDR
        |-> q.cfg.cmd == SPI2_CMD && q.cfg.dummy == 3'h4 && q.cfg.div == 8'h02)
        else $error("spi mode 2 defaults wrong");
    a_i2c_first: assert property ($rose(q.state == PH_HDR) && q.cfg.kind == ROM_I2C
        |-> q.tx_valid && q.tx_byte == 8'hA0)
        else $error("i2c device byte wrong");
    a_flash_timing: assert property (q.state == PH_FETCH && q.mode == M_FL8
        |-> q.cfg.acc_dly == 3'h4 && q.cfg.oe_dly == 3'h0 && q.cfg.cs_low)
        else $error("flash timing defaults wrong");
    a_stall_assert: assert property (msg_valid && init_busy |=> !host_stall_pin_n)
        else $error("stall pin not driven low");
    a_stall_discard: assert property (!q.stall_n && msg_valid
        && (q.state == PH_IDLE || q.state == PH_HOSTLOAD)
        |=> $stable(q.resp) && $stable(q.state))
        else $error("message taken while stalled");
    a_end_reply: assert property (s_end_taken
        |=> (resp_code == RSP_LOAD_OK || resp_code == RSP_SUM_ERR)
        && !(host_read_pending_pin_n && parallel_read_pending_pin_n))
        else $error("no checksum reply");
    a_run_start: assert property (s_run_taken |=> app_run ##1 app_run)
        else $error("start-run not honoured");
endmodule

// [bml_pkg.sv]
/*
 Shared types and constants for the boot mode select and image loader.
 Assumes one core clock and a synchronous, active-high reset.
*/
package bml_pkg;

    localparam int STRAP_W = 5;
    localparam int SUM_W = 32;
    localparam int DIV_W = 8;

    typedef enum logic [3:0] {
        M_I2C = 4'b0000,
        M_SPI1 = 4'b0001,
        M_SPI2 = 4'b0010,
        M_SPI3 = 4'b0011,
        M_FL8 = 4'b0100,
        M_FL16 = 4'b0101,
        S_I2C = 4'b1000,
        S_SPI = 4'b1001,
        S_PAR_SEP = 4'b1010,
        S_PAR_RW = 4'b1011,
        S_PAR_MUX = 4'b1100
    } bml_mode_e;

    typedef enum logic [1:0] {
        ROM_I2C = 2'b00,
        ROM_SPI = 2'b01,
        ROM_PAR = 2'b10
    } bml_rom_e;

    typedef enum logic [2:0] {
        PH_CAPTURE = 3'b000,
        PH_IDLE = 3'b001,
        PH_HOSTLOAD = 3'b010,
        PH_HDR = 3'b011,
        PH_FETCH = 3'b100,
        PH_RUN = 3'b101
    } bml_state_e;

    // Fixed master boot parameters
    localparam logic [6:0] I2C_DEV_ADDR = 7'h50;
    localparam logic [7:0] I2C_DIV = 8'h48;
    localparam logic [7:0] SPI1_CMD = 8'h03;
    localparam logic [7:0] SPI1_DIV = 8'h04;
    localparam logic [7:0] SPI2_CMD = 8'h68;
    localparam logic [2:0] SPI2_DUMMY = 3'h4;
    localparam logic [7:0] SPI3_CMD = 8'h03;
    localparam logic [7:0] SPI23_DIV = 8'h02;
    localparam logic [1:0] ADDR_16 = 2'h2;
    localparam logic [1:0] ADDR_24 = 2'h3;
    localparam logic [23:0] IMAGE_START = 24'h00_0000;
    localparam logic [5:0] CS_PIN_DEFAULT = 6'h14;
    localparam logic [1:0] FLASH_RATIO = 2'h1;
    localparam logic [2:0] FLASH_OE_DLY = 3'h0;
    localparam logic [2:0] FLASH_ACC_DLY = 3'h4;

    // Host message codes and argument fields
    localparam logic [3:0] MSG_SLAVE_BOOT = 4'h1;
    localparam logic [3:0] MSG_ROM_BOOT = 4'h2;
    localparam logic [3:0] MSG_WORD = 4'h3;
    localparam logic [3:0] MSG_END = 4'h4;
    localparam logic [3:0] MSG_RUN = 4'h5;
    localparam int ARG_DIV_LSB = 0;
    localparam int ARG_CS_LSB = 8;
    localparam int ARG_KIND_LSB = 14;

    // Response codes
    localparam logic [7:0] RSP_START = 8'h01;
    localparam logic [7:0] RSP_LOAD_OK = 8'h02;
    localparam logic [7:0] RSP_SUM_ERR = 8'h03;
    localparam logic [7:0] RSP_RUN = 8'h04;

    typedef struct packed {
        logic [3:0] code;
        logic [15:0] arg;
        logic [31:0] data;
    } bml_msg_s;

    typedef struct packed {
        bml_rom_e kind;
        logic [7:0] cmd;
        logic [1:0] addr_bytes;
        logic [2:0] dummy;
        logic [7:0] div;
        logic [5:0] cs_pin;
        logic [23:0] addr;
        logic wide;
        logic cs_low;
        logic little;
        logic [1:0] ratio;
        logic [2:0] oe_dly;
        logic [2:0] acc_dly;
    } bml_rom_cfg_s;

endpackage

// [bml_div.sv]
/*
 Serial clock pacing divider: one-cycle tick every div clocks.
 Assumes div is at least one and stable while en is high.
*/
`timescale 1ns/1ps
module bml_div
    import bml_pkg::*;
#(
    parameter int W = DIV_W
)(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic en,
    input wire logic [W-1:0] div,
    output logic tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } bml_div_s;

    bml_div_s q;
    bml_div_s d;

    always_comb
    begin
        d = q;
        d.tick = 1'b0;
        if (!en)
        begin
            d.cnt = '0;
        end
        else if (q.cnt >= div - W'(1))
        begin
            d.cnt = '0;
            d.tick = 1'b1;
        end
        else
        begin
            d.cnt = q.cnt + W'(1);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    assign tick = q.tick;
endmodule

// [bml_sum.sv]
/*
 Running image checksum accumulator.
 Assumes clear and add are never requested in the same cycle.
*/
`timescale 1ns/1ps
module bml_sum
    import bml_pkg::*;
#(
    parameter int W = SUM_W
)(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic add,
    input wire logic [W-1:0] val,
    output logic [W-1:0] sum
);
    typedef struct packed {
        logic [W-1:0] acc;
    } bml_sum_s;

    bml_sum_s q;
    bml_sum_s d;

    always_comb
    begin
        d = q;
        if (clr)
            d.acc = '0;
        else if (add)
            d.acc = q.acc + val;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    assign sum = q.acc;
endmodule

// [bml_rom_model.sv]
/*
 Behavioural external boot ROM engine: takes header bytes, returns an image.
 Assumes the loader's rom_tx/rom_rx handshake on the one core clock.
*/
`timescale 1ns/1ps
module bml_rom_model
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic rom_tx_valid,
    input wire logic [7:0] rom_tx_byte,
    output logic rom_tx_ready,
    output logic rom_rx_valid,
    output logic [7:0] rom_rx_byte,
    output logic rom_rx_last,
    output logic [63:0] hdr_q,
    output logic [3:0] hcnt_q
);
    initial
    begin
        rom_tx_ready = 1'b0;
        rom_rx_valid = 1'b0;
        rom_rx_byte = 8'h00;
        rom_rx_last = 1'b0;
    end
    // Header bytes collected; ready only every other cycle when slow
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            hdr_q <= '0;
            hcnt_q <= '0;
            rom_tx_ready <= 1'b0;
        end
        else
        begin
            if (rom_tx_valid && rom_tx_ready)
            begin
                hdr_q <= {hdr_q[55:0], rom_tx_byte};
                hcnt_q <= hcnt_q + 4'h1;
            end
            rom_tx_ready <= slow ? !rom_tx_ready : 1'b1;
        end
    end
    // Three data bytes then the checksum byte; idle data is inverted
    task send_image(input logic good);
        logic [7:0] b [4];
        b = '{8'h11, 8'h22, 8'h33, good ? 8'h9A : 8'h9B};
        for (int i = 0; i < 4; i++)
        begin
            @(posedge ref_clk);
            rom_rx_valid <= 1'b1;
            rom_rx_byte <= b[i];
            rom_rx_last <= (i == 3);
        end
        @(posedge ref_clk);
        rom_rx_valid <= 1'b0;
        rom_rx_last <= 1'b0;
        rom_rx_byte <= ~b[3];
    endtask
endmodule

// [bml_loader_tb.sv]
/*
 Self-checking bench for the boot mode select and image loader.
 Assumes bml_rom_model stands on the ROM side; bench plays the host.
*/
`timescale 1ns/1ps
module bml_loader_tb;
    import bml_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] pins;
    logic init_busy, msg_valid, resp_read, slow;
    bml_msg_s msg;
    logic tx_rdy, rx_v, rx_last, tx_v, tick_o, stall_n, pend_n, ppend_n, app_run;
    logic [7:0] rx_b, tx_b, resp;
    logic [63:0] hdr;
    logic [3:0] hcnt;
    bml_mode_e boot_mode;
    bml_state_e boot_state;
    bml_rom_cfg_s cfg;
    int err_count, checks_done, cyc = 0;
    logic [4:0] st [6] = '{5'h10, 5'h08, 5'h01, 5'h19, 5'h02, 5'h0A};
    bml_mode_e md [6] = '{M_I2C, M_SPI1, M_SPI2, M_SPI3, M_FL8, M_FL16};
    logic [63:0] eh [6] = '{64'h0000_0000_00A0_0000, 64'h0000_0000_0003_0000,
        64'h6800_0000_0000_0000, 64'h0000_0000_0300_0000, 64'h0, 64'h0};
    logic [3:0] en [6] = '{4'h3, 4'h3, 4'h8, 4'h4, 4'h0, 4'h0};
    logic [7:0] dv [6] = '{8'h48, 8'h04, 8'h02, 8'h02, 8'h00, 8'h00};

    always #12.5 ref_clk = ~ref_clk;

    bml_loader uut (.ref_clk(ref_clk), .rst(rst), .boot_select_pins(pins),
        .init_busy(init_busy), .msg_valid(msg_valid), .msg(msg), .resp_read(resp_read),
        .rom_tx_ready(tx_rdy), .rom_rx_valid(rx_v), .rom_rx_byte(rx_b),
        .rom_rx_last(rx_last), .boot_mode(boot_mode), .boot_state(boot_state),
        .rom_cfg(cfg), .rom_tx_valid(tx_v), .rom_tx_byte(tx_b), .rom_clk_tick(tick_o),
        .resp_code(resp), .host_stall_pin_n(stall_n), .host_read_pending_pin_n(pend_n),
        .parallel_read_pending_pin_n(ppend_n), .app_run(app_run));
    bml_rom_model rom (.ref_clk(ref_clk), .rst(rst), .slow(slow), .rom_tx_valid(tx_v),
        .rom_tx_byte(tx_b), .rom_tx_ready(tx_rdy), .rom_rx_valid(rx_v),
        .rom_rx_byte(rx_b), .rom_rx_last(rx_last), .hdr_q(hdr), .hcnt_q(hcnt));

    task wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Run is cut short here if a wait hangs
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            wrap_up();
        end
    end
    task chk(input logic [71:0] got, input logic [71:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task do_reset(input logic [4:0] p);
        @(posedge ref_clk);
        rst <= 1'b1;
        pins <= p;
        tick(2);
        chk({stall_n, pend_n, ppend_n, app_run, tx_v}, 5'h1C);
        @(posedge ref_clk);
        rst <= 1'b0;
        tick(3);
    endtask
    task wait_state(input bml_state_e s);
        #1;
        for (int k = 0; k < 300 && boot_state !== s; k++)
            tick(1);
    endtask
    task send(input logic [3:0] c, input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        msg_valid <= 1'b1;
        msg <= {c, a, d};
        @(posedge ref_clk);
        msg_valid <= 1'b0;
        msg <= ~{c, a, d};
    endtask
    task wait_pend();
        #1;
        for (int k = 0; k < 8 && pend_n !== 1'b0 && ppend_n !== 1'b0; k++)
            tick(1);
    endtask
    task reply(input logic [7:0] e);
        wait_pend();
        chk(resp, e);
        @(posedge ref_clk);
        resp_read <= 1'b1;
        @(posedge ref_clk);
        resp_read <= 1'b0;
        tick(1);
        chk({pend_n, ppend_n}, 2'b11);
    endtask
    task measure(input logic [7:0] d);
        int k;
        k = 0;
        while (k < 300 && tick_o !== 1'b1)
        begin
            tick(1);
            k++;
        end
        k = 0;
        do
        begin
            tick(1);
            k++;
        end while (k < 300 && tick_o !== 1'b1);
        chk(k, d);
    endtask

    task t_master();
        for (int i = 0; i < 6; i++)
        begin
            slow <= i[0];
            do_reset(st[i]);
            chk(boot_mode, md[i]);
            @(posedge ref_clk);
            pins <= ~st[i];
            wait_state(PH_FETCH);
            chk(boot_mode, md[i]);
            chk({hcnt, hdr}, {en[i], eh[i]});
            if (i < 4)
            begin
                chk(cfg.div, dv[i]);
                measure(dv[i]);
            end
            if (i > 0 && i < 4)
                chk(cfg.cs_pin, 6'h14);
            if (i > 3)
                chk({cfg.wide, cfg.cs_low, cfg.little, cfg.ratio, cfg.oe_dly, cfg.acc_dly},
                    {i == 5, 2'b11, FLASH_RATIO, 3'h0, 3'h4});
            rom.send_image(i != 3);
            wait_pend();
            chk({resp, app_run}, {(i == 3) ? 8'h03 : 8'h02, i != 3});
        end
        slow <= 1'b0;
        $display("test master done");
    endtask

    task t_slave();
        logic [4:0] sp [5];
        bml_mode_e sm [5];
        sp = '{5'h04, 5'h1D, 5'h0E, 5'h17, 5'h1B};
        sm = '{S_I2C, S_SPI, S_PAR_SEP, S_PAR_RW, S_PAR_MUX};
        for (int j = 0; j < 5; j++)
        begin
            do_reset(sp[j]);
            chk({boot_mode, boot_state}, {sm[j], PH_IDLE});
            send(MSG_SLAVE_BOOT, 16'h0000, 32'h0000_0000);
            wait_pend();
            chk({pend_n, ppend_n}, (j > 1) ? 2'b10 : 2'b01);
            reply(RSP_START);
        end
        $display("test slave modes done");
    endtask

    task t_host();
        do_reset(5'h05);
        @(posedge ref_clk);
        init_busy <= 1'b1;
        send(MSG_SLAVE_BOOT, 16'h0000, 32'h0000_0000);
        tick(2);
        chk({stall_n, pend_n}, 2'b01);
        @(posedge ref_clk);
        init_busy <= 1'b0;
        msg_valid <= 1'b1;
        msg <= {MSG_SLAVE_BOOT, 16'h0000, 32'h0000_0000};
        @(posedge ref_clk);
        msg_valid <= 1'b0;
        tick(3);
        chk({stall_n, pend_n}, 2'b11);
        send(MSG_SLAVE_BOOT, 16'h0000, 32'h0000_0000);
        reply(RSP_START);
        send(MSG_WORD, 16'h0000, 32'h1000_0001);
        send(MSG_WORD, 16'h0000, 32'h2000_0002);
        send(MSG_END, 16'h0000, 32'h3000_0003);
        reply(RSP_LOAD_OK);
        send(MSG_SLAVE_BOOT, 16'h0000, 32'h0000_0000);
        reply(RSP_START);
        send(MSG_WORD, 16'h0000, 32'h0000_0005);
        send(MSG_END, 16'h0000, 32'h0000_0006);
        reply(RSP_SUM_ERR);
        send(MSG_ROM_BOOT, 16'h4506, 32'h0012_3456);
        reply(RSP_START);
        wait_state(PH_FETCH);
        chk({cfg.kind, cfg.cs_pin, cfg.div}, {ROM_SPI, 6'h05, 8'h06});
        chk({hcnt, hdr}, {4'h4, 64'h0000_0000_0312_3456});
        rom.send_image(1'b1);
        wait_pend();
        chk({pend_n, ppend_n}, 2'b01);
        reply(RSP_LOAD_OK);
        send(MSG_SLAVE_BOOT, 16'h0000, 32'h0000_0000);
        reply(RSP_START);
        send(MSG_END, 16'h0000, 32'h0000_0000);
        reply(RSP_LOAD_OK);
        send(MSG_RUN, 16'h0000, 32'h0000_0000);
        reply(RSP_RUN);
        chk(app_run, 1'b1);
        $display("test host boot done");
    endtask

    initial
    begin
        pins = 5'h00;
        init_busy = 1'b0;
        msg_valid = 1'b0;
        msg = '0;
        resp_read = 1'b0;
        slow = 1'b0;
        err_count = 0;
        checks_done = 0;
        repeat (20) @(posedge ref_clk);
        t_master();
        t_slave();
        t_host();
        wrap_up();
    end
endmodule
